// File: hw/psw_gen.sv
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
module psw_gen #(
   parameter logic [15:0] TICK_CYCLES = 16'(psw_pkg::TICK_CYCLES)
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [95:0] ANALOG_OUT_GROUP_A_CODE,
   output logic [7:0] ANALOG_OUT_GROUP_A_HIZ,
   output logic [95:0] ANALOG_OUT_GROUP_B_CODE,
   output logic [7:0] ANALOG_OUT_GROUP_B_HIZ,
   output logic [15:0] PATTERN_PINS_BANK_ONE_O,
   output logic [15:0] PATTERN_PINS_BANK_ONE_OE,
   output logic [15:0] PATTERN_PINS_BANK_ONE_PU,
   output logic [15:0] PATTERN_PINS_BANK_ONE_PD,
   output logic [15:0] PATTERN_PINS_BANK_TWO_O,
   output logic [15:0] PATTERN_PINS_BANK_TWO_OE,
   output logic [15:0] PATTERN_PINS_BANK_TWO_PU,
   output logic [15:0] PATTERN_PINS_BANK_TWO_PD
);
   // Apply one point to the previous output state; steps saturate
   function automatic psw_pkg::psw_os_t psw_apply(input psw_pkg::psw_os_t base,
                                                  input psw_pkg::psw_pt_t p);
      psw_pkg::psw_os_t r;
      logic [12:0] s;
      r.hiz = 1'b0;
      r.code = p.code;
      s = 13'h0000;
      case (p.kind)
         psw_pkg::KIND_HIZ: r = psw_pkg::OS_HIZ;
         psw_pkg::KIND_ZERO: r = psw_pkg::OS_ZERO;
         psw_pkg::KIND_STEP: begin
            if (p.sub) begin
               s = {1'b0, base.code} - {1'b0, p.code};
               r.code = s[12] ? 12'h000 : s[11:0];
            end else begin
               s = {1'b0, base.code} + {1'b0, p.code};
               r.code = s[12] ? psw_pkg::DAC_MAX : s[11:0];
            end
         end
         default: r.code = p.code;
      endcase
      return r;
   endfunction : psw_apply

   // Point memory: 64 rows by 256 slots for 48 channels, slots past the channel limit unused
   logic [31:0] pt_mem [0:16383];
   psw_pkg::psw_cfg_t cfg_q [0:47];
   psw_pkg::psw_pt_t pre_q [0:47];
   psw_pkg::psw_st_t st_q [0:47];
   logic [7:0] idx_q [0:47];
   logic [15:0] rem_q [0:47];
   logic [7:0] pas_q [0:47];
   logic pau_q [0:47];
   logic [1:0] cmd_q [0:47];
   psw_pkg::psw_os_t lst_q [0:47];
   psw_pkg::psw_os_t shd_q [0:47];

   logic [15:0] tick_cnt_q;
   logic scan_q;
   logic [5:0] sc_q;
   logic [5:0] csel_q;
   logic [7:0] paddr_q;

   // Sample tick and channel scan; scan is 48 cycles, well inside one tick
   wire tick = (tick_cnt_q == TICK_CYCLES - 16'h0001);
   wire scan_last = (sc_q == 6'(psw_pkg::N_CH - 1));

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         tick_cnt_q <= 16'h0000;
         scan_q <= 1'b0;
         sc_q <= 6'h00;
      end else begin
         tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
         scan_q <= tick | (scan_q & ~scan_last);
         sc_q <= (tick | scan_last) ? 6'h00 : sc_q + 6'(scan_q);
      end
   end

   // Per-channel step for the channel under scan
   wire is_dig = (sc_q >= 6'(psw_pkg::N_ANA));
   psw_pkg::psw_cfg_t c;
   assign c = cfg_q[sc_q];
   wire [7:0] lim = is_dig ? psw_pkg::MAX_PTS_DIG : psw_pkg::MAX_PTS_ANA;
   wire [7:0] np = (c.npts == 8'h00) ? 8'h01 : (c.npts > lim) ? lim : c.npts;
   wire [1:0] cm = cmd_q[sc_q];
   wire fresh = (cm == psw_pkg::CMD_START) &&
                (st_q[sc_q] == psw_pkg::ST_IDLE || st_q[sc_q] == psw_pkg::ST_DONE);
   wire active_now = (st_q[sc_q] == psw_pkg::ST_PRE || st_q[sc_q] == psw_pkg::ST_RUN);

   // State after the pending command; each channel sees only its own
   psw_pkg::psw_st_t e_st;
   assign e_st = (cm == psw_pkg::CMD_STOP) ? psw_pkg::ST_DONE :
                 fresh ? (c.pre_en ? psw_pkg::ST_PRE : psw_pkg::ST_RUN) : st_q[sc_q];
   wire [7:0] e_idx = fresh ? 8'h00 : idx_q[sc_q];
   wire [15:0] e_rem = fresh ? 16'h0000 : rem_q[sc_q];
   wire [7:0] e_pas = fresh ? 8'h00 : pas_q[sc_q];
   // Pause only freezes; start clears it and resumes the frozen counters
   wire e_pau = (cm == psw_pkg::CMD_PAUSE) ? active_now :
                (cm == psw_pkg::CMD_NONE) ? pau_q[sc_q] : 1'b0;

   wire e_pre = (e_st == psw_pkg::ST_PRE);
   wire e_run = (e_st == psw_pkg::ST_RUN);
   wire stepping = (e_pre | e_run) & ~e_pau;
   wire load = stepping & (e_rem == 16'h0000);
   wire ld_pre = e_pre & (e_idx == 8'h00);
   wire wrap = e_run & (e_idx >= np);
   wire [7:0] pas_inc = e_pas + 8'h01;
   wire fin = load & wrap & (c.reps != 8'h00) & (pas_inc == c.reps);
   wire [7:0] ld_i = (e_pre | wrap) ? 8'h00 : e_idx;
   psw_pkg::psw_pt_t ld_pt;
   assign ld_pt = ld_pre ? pre_q[sc_q] : psw_pkg::psw_pt_t'(pt_mem[{sc_q, ld_i}]);
   psw_pkg::psw_pt_t first_pt;
   assign first_pt = psw_pkg::psw_pt_t'(pt_mem[{sc_q, 8'h00}]);
   psw_pkg::psw_os_t first_os;
   assign first_os = psw_apply(psw_pkg::OS_ZERO, first_pt);
   psw_pkg::psw_os_t ld_os;
   assign ld_os = psw_apply(lst_q[sc_q], ld_pt);
   wire do_ld = load & ~fin;

   psw_pkg::psw_st_t n_st;
   assign n_st = fin ? psw_pkg::ST_DONE : (do_ld & ~ld_pre) ? psw_pkg::ST_RUN : e_st;
   wire [7:0] n_idx = do_ld ? (ld_pre ? 8'h01 : ld_i + 8'h01) : e_idx;
   // Zero duration is read as one tick
   wire [15:0] n_rem = do_ld ? ((ld_pt.dur == 16'h0000) ? 16'h0000 : ld_pt.dur - 16'h0001) :
                       (stepping & ~load) ? e_rem - 16'h0001 : e_rem;
   wire [7:0] n_pas = (load & wrap) ? pas_inc : e_pas;
   psw_pkg::psw_os_t n_lst;
   assign n_lst = do_ld ? ld_os : lst_q[sc_q];

   // Displayed state from idle, pause and end modes
   psw_pkg::psw_os_t idle_os;
   assign idle_os = (c.idle_mode == psw_pkg::MODE_HIZ) ? psw_pkg::OS_HIZ :
                    (c.idle_mode == psw_pkg::MODE_ZERO) ? psw_pkg::OS_ZERO : first_os;
   psw_pkg::psw_os_t pause_os;
   assign pause_os = (c.pause_mode == psw_pkg::MODE_HIZ) ? psw_pkg::OS_HIZ :
                     (c.pause_mode == psw_pkg::MODE_ZERO) ? psw_pkg::OS_ZERO :
                     (c.pause_mode == psw_pkg::MODE_FIRST) ? first_os : n_lst;
   psw_pkg::psw_os_t end_os;
   assign end_os = (c.end_mode == psw_pkg::END_LAST) ? n_lst : first_os;
   psw_pkg::psw_os_t disp;
   assign disp = (n_st == psw_pkg::ST_IDLE) ? idle_os :
                 (n_st == psw_pkg::ST_DONE) ? end_os :
                 e_pau ? pause_os : n_lst;

   // AXI4-Lite slave
   logic aw_h_q;
   logic w_h_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Two-entry buffer between point writes and the point memory
   logic [45:0] fb_q [0:1];
   logic [1:0] fcnt_q;
   logic frd_q;
   wire f_in_rdy = (fcnt_q != 2'h2);
   wire f_out_vld = (fcnt_q != 2'h0);
   // Memory is read by the scan, so writes stall while it runs
   wire f_out_rdy = ~scan_q;
   wire f_pop = f_out_vld & f_out_rdy;

   wire w_cmd = (awaddr_q == psw_pkg::OFS_CMD);
   wire w_dst = (awaddr_q == psw_pkg::OFS_DSTART);
   wire w_csel = (awaddr_q == psw_pkg::OFS_CSEL);
   wire w_cfg = (awaddr_q == psw_pkg::OFS_CFG);
   wire w_pre = (awaddr_q == psw_pkg::OFS_PRE);
   wire w_padr = (awaddr_q == psw_pkg::OFS_PADDR);
   wire w_pdat = (awaddr_q == psw_pkg::OFS_PDATA);
   wire w_ok = w_cmd | w_dst | w_csel | w_cfg | w_pre | w_padr | w_pdat;
   wire wr_go = aw_h_q & w_h_q & ~bvalid_q & (~w_pdat | f_in_rdy);
   wire wr_full = (wstrb_q == 4'hf);
   wire [5:0] wch = wdata_q[5:0];
   wire csel_dig = (csel_q >= 6'(psw_pkg::N_ANA));
   wire [7:0] plim = csel_dig ? psw_pkg::MAX_PTS_DIG : psw_pkg::MAX_PTS_ANA;
   wire f_push = wr_go & w_pdat & wr_full & (paddr_q < plim) & (csel_q < 6'(psw_pkg::N_CH));

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         aw_h_q <= 1'b0;
         w_h_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= psw_pkg::RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID & awready_q) begin
            awaddr_q <= {S_AXI_AWADDR[11:2], 2'h0};
         end
         if (S_AXI_WVALID & wready_q) begin
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         aw_h_q <= (aw_h_q & ~wr_go) | (S_AXI_AWVALID & awready_q);
         w_h_q <= (w_h_q & ~wr_go) | (S_AXI_WVALID & wready_q);
         awready_q <= ~aw_h_q & ~(S_AXI_AWVALID & awready_q) & ~bvalid_q;
         wready_q <= ~w_h_q & ~(S_AXI_WVALID & wready_q) & ~bvalid_q;
         bvalid_q <= wr_go | (bvalid_q & ~S_AXI_BREADY);
         if (wr_go) begin
            bresp_q <= w_ok ? psw_pkg::RESP_OKAY : psw_pkg::RESP_SLVERR;
         end
      end
   end

   // Buffer storage and point memory write
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         fcnt_q <= 2'h0;
         frd_q <= 1'b0;
      end else begin
         fcnt_q <= fcnt_q + 2'(f_push) - 2'(f_pop);
         frd_q <= frd_q ^ f_pop;
      end
      if (f_push) begin
         fb_q[frd_q ^ fcnt_q[0]] <= {csel_q, paddr_q, wdata_q};
      end
      if (f_pop) begin
         pt_mem[fb_q[frd_q][45:32]] <= fb_q[frd_q][31:0];
      end
   end

   // Configuration writes
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         csel_q <= 6'h00;
         paddr_q <= 8'h00;
         for (int i = 0; i < psw_pkg::N_CH; i++) begin
            cfg_q[i] <= psw_pkg::CFG_RST;
            pre_q[i] <= psw_pkg::PT_RST;
         end
      end else if (wr_go & wr_full) begin
         if (w_csel) begin
            csel_q <= wch;
         end else if (w_padr) begin
            paddr_q <= wdata_q[7:0];
         end else if (w_pdat) begin
            paddr_q <= paddr_q + 8'h01;
         end else if (w_cfg && csel_q < 6'(psw_pkg::N_CH)) begin
            cfg_q[csel_q] <= psw_pkg::psw_cfg_t'(wdata_q);
         end else if (w_pre && csel_q < 6'(psw_pkg::N_CH)) begin
            pre_q[csel_q] <= psw_pkg::psw_pt_t'(wdata_q);
         end
      end
   end

   // Channel state; a new command beats the scan's clear in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         for (int i = 0; i < psw_pkg::N_CH; i++) begin
            st_q[i] <= psw_pkg::ST_IDLE;
            idx_q[i] <= 8'h00;
            rem_q[i] <= 16'h0000;
            pas_q[i] <= 8'h00;
            pau_q[i] <= 1'b0;
            cmd_q[i] <= psw_pkg::CMD_NONE;
            lst_q[i] <= psw_pkg::OS_HIZ;
            shd_q[i] <= psw_pkg::OS_HIZ;
         end
      end else begin
         if (scan_q) begin
            st_q[sc_q] <= n_st;
            idx_q[sc_q] <= n_idx;
            rem_q[sc_q] <= n_rem;
            pas_q[sc_q] <= n_pas;
            pau_q[sc_q] <= e_pau;
            lst_q[sc_q] <= n_lst;
            shd_q[sc_q] <= disp;
            cmd_q[sc_q] <= psw_pkg::CMD_NONE;
         end
         if (wr_go & wr_full & w_cmd & (wch < 6'(psw_pkg::N_CH))) begin
            cmd_q[wch] <= wdata_q[psw_pkg::CMD_OP_LSB +: 2];
         end
         // Shared start so every digital channel takes its first point on one tick, unless written while the scan is on channels 16 to 46
         if (wr_go & wr_full & w_dst) begin
            for (int i = psw_pkg::N_ANA; i < psw_pkg::N_CH; i++) begin
               if (wdata_q[psw_pkg::DSTART_STOP_BIT]) begin
                  cmd_q[i] <= psw_pkg::CMD_STOP;
               end else if (wdata_q[psw_pkg::DSTART_GO_BIT]) begin
                  cmd_q[i] <= psw_pkg::CMD_START;
               end
            end
         end
      end
   end

   // Pin structure from level and output type
   logic [31:0] d_o;
   logic [31:0] d_oe;
   logic [31:0] d_pu;
   logic [31:0] d_pd;
   always_comb begin
      for (int i = 0; i < psw_pkg::N_DIG; i++) begin
         logic lvl;
         logic drv;
         lvl = (shd_q[i + psw_pkg::N_ANA].code != 12'h000);
         drv = ~shd_q[i + psw_pkg::N_ANA].hiz;
         d_o[i] = 1'b0;
         d_oe[i] = 1'b0;
         d_pu[i] = 1'b0;
         d_pd[i] = 1'b0;
         case (cfg_q[i + psw_pkg::N_ANA].otype)
            psw_pkg::OT_PUSHPULL: begin
               d_o[i] = lvl;
               d_oe[i] = drv;
            end
            psw_pkg::OT_OD_NMOS: d_oe[i] = drv & ~lvl;
            psw_pkg::OT_OD_PMOS: begin
               d_o[i] = 1'b1;
               d_oe[i] = drv & lvl;
            end
            psw_pkg::OT_PULLUP: d_pu[i] = 1'b1;
            psw_pkg::OT_PULLDN: d_pd[i] = 1'b1;
            default: d_oe[i] = 1'b0;
         endcase
      end
   end

   // All outputs take the last scan's results on one tick edge
   logic [191:0] acode_q;
   logic [15:0] ahiz_q;
   logic [31:0] do_q;
   logic [31:0] doe_q;
   logic [31:0] dpu_q;
   logic [31:0] dpd_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         acode_q <= '0;
         ahiz_q <= 16'hffff;
         do_q <= 32'h0000_0000;
         doe_q <= 32'h0000_0000;
         dpu_q <= 32'h0000_0000;
         dpd_q <= 32'h0000_0000;
      end else if (tick) begin
         for (int i = 0; i < psw_pkg::N_ANA; i++) begin
            acode_q[i*12 +: 12] <= shd_q[i].code;
            ahiz_q[i] <= shd_q[i].hiz;
         end
         do_q <= d_o;
         doe_q <= d_oe;
         dpu_q <= d_pu;
         dpd_q <= d_pd;
      end
   end

   // Register read port, one cycle after address
   logic [5:0] rch;
   assign rch = (csel_q < 6'(psw_pkg::N_CH)) ? csel_q : 6'h00;
   wire [31:0] stat_w = {8'h00, pas_q[rch], idx_q[rch], 3'h0, pau_q[rch], st_q[rch]};
   wire [11:0] ra = {S_AXI_ARADDR[11:2], 2'h0};
   logic [31:0] rd_w;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      if (ra == psw_pkg::OFS_CMD) begin
         rd_w = {22'h0, cmd_q[rch], 2'h0, csel_q};
      end else if (ra == psw_pkg::OFS_CSEL) begin
         rd_w = {26'h0, csel_q};
      end else if (ra == psw_pkg::OFS_CFG) begin
         rd_w = cfg_q[rch];
      end else if (ra == psw_pkg::OFS_PRE) begin
         rd_w = pre_q[rch];
      end else if (ra == psw_pkg::OFS_PADDR) begin
         rd_w = {24'h0, paddr_q};
      end else if (ra == psw_pkg::OFS_STAT) begin
         rd_w = stat_w;
      end else if (ra == psw_pkg::OFS_DPINS) begin
         rd_w = do_q;
      end else begin
         rd_w = 32'h0000_0000;
         rd_ok = (ra == psw_pkg::OFS_DSTART) | (ra == psw_pkg::OFS_PDATA);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= psw_pkg::RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_q & ~(S_AXI_ARVALID & arready_q);
         rvalid_q <= (S_AXI_ARVALID & arready_q) | (rvalid_q & ~S_AXI_RREADY);
         if (S_AXI_ARVALID & arready_q) begin
            rdata_q <= rd_w;
            rresp_q <= rd_ok ? psw_pkg::RESP_OKAY : psw_pkg::RESP_SLVERR;
         end
      end
   end

   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign ANALOG_OUT_GROUP_A_CODE = acode_q[95:0];
   assign ANALOG_OUT_GROUP_B_CODE = acode_q[191:96];
   assign ANALOG_OUT_GROUP_A_HIZ = ahiz_q[7:0];
   assign ANALOG_OUT_GROUP_B_HIZ = ahiz_q[15:8];
   assign PATTERN_PINS_BANK_ONE_O = do_q[15:0];
   assign PATTERN_PINS_BANK_ONE_OE = doe_q[15:0];
   assign PATTERN_PINS_BANK_ONE_PU = dpu_q[15:0];
   assign PATTERN_PINS_BANK_ONE_PD = dpd_q[15:0];
   assign PATTERN_PINS_BANK_TWO_O = do_q[31:16];
   assign PATTERN_PINS_BANK_TWO_OE = doe_q[31:16];
   assign PATTERN_PINS_BANK_TWO_PU = dpu_q[31:16];
   assign PATTERN_PINS_BANK_TWO_PD = dpd_q[31:16];
endmodule : psw_gen

// File: hw/psw_pkg.sv
// Function
// - All analog outputs refresh together once per sample tick at 10 kS/s.
// - Analog point state: high impedance, zero, absolute level, or add/subtract step.
// - Each point holds its state for 1 to 65535 sample ticks of 100 us.
// - Each analog channel plays at most 60 points in order.
// - Sixteen analog generator channels, each with its own point sequence.
// - Start, pause and stop act per analog channel without touching others.
// - Waveform replays a programmed count up to 255, or until stopped.
// - Repeat count zero means endless replay; 1 to 255 give exact passes.
// - Optional pre-start state plays once before the first point only.
// - Output before start: high impedance, zero, or first point state.
// - Output while paused: high impedance, zero, first point, or last state.
// - Output after completion: first point state or last output state.
// - Thirty-two independent digital channels, each driving one pin.
// - Digital point pairs a pin level with a tick duration.
// - Digital channels share one start instant and a common 10 kS/s tick; a start written while the scan is on channels 16 to 46 splits over two ticks.
// - Digital sequencing matches analog, with up to 181 points per channel.
// - Digital pin structure: push-pull, Hi-Z, open-drain N/P, pull-up, pull-down.
package psw_pkg;
   localparam int N_ANA = 16;
   localparam int N_DIG = 32;
   localparam int N_CH = 48;
   localparam logic [7:0] MAX_PTS_ANA = 8'h3c;
   localparam logic [7:0] MAX_PTS_DIG = 8'hb5;
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int SAMPLE_HZ = 10_000;
   localparam int TICK_CYCLES = SYS_CLK_HZ / SAMPLE_HZ;
   localparam logic [11:0] DAC_MAX = 12'hfff;

   // Register byte offsets
   localparam logic [11:0] OFS_CMD = 12'h000;
   localparam logic [11:0] OFS_DSTART = 12'h004;
   localparam logic [11:0] OFS_CSEL = 12'h008;
   localparam logic [11:0] OFS_CFG = 12'h00c;
   localparam logic [11:0] OFS_PRE = 12'h010;
   localparam logic [11:0] OFS_PADDR = 12'h014;
   localparam logic [11:0] OFS_PDATA = 12'h018;
   localparam logic [11:0] OFS_STAT = 12'h01c;
   localparam logic [11:0] OFS_DPINS = 12'h020;
   localparam int CMD_OP_LSB = 8;
   localparam int DSTART_GO_BIT = 0;
   localparam int DSTART_STOP_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_START = 2'h1;
   localparam logic [1:0] CMD_PAUSE = 2'h2;
   localparam logic [1:0] CMD_STOP = 2'h3;

   localparam logic [1:0] KIND_HIZ = 2'h0;
   localparam logic [1:0] KIND_ZERO = 2'h1;
   localparam logic [1:0] KIND_ABS = 2'h2;
   localparam logic [1:0] KIND_STEP = 2'h3;

   // Idle/pause mode codes (pause adds LAST), end mode codes
   localparam logic [1:0] MODE_HIZ = 2'h0;
   localparam logic [1:0] MODE_ZERO = 2'h1;
   localparam logic [1:0] MODE_FIRST = 2'h2;
   localparam logic [1:0] MODE_LAST = 2'h3;
   localparam logic END_FIRST = 1'b0;
   localparam logic END_LAST = 1'b1;

   localparam logic [2:0] OT_PUSHPULL = 3'h0;
   localparam logic [2:0] OT_HIZ = 3'h1;
   localparam logic [2:0] OT_OD_NMOS = 3'h2;
   localparam logic [2:0] OT_OD_PMOS = 3'h3;
   localparam logic [2:0] OT_PULLUP = 3'h4;
   localparam logic [2:0] OT_PULLDN = 3'h5;

   typedef struct packed {
      logic [11:0] code;
      logic rsvd;
      logic sub;
      logic [1:0] kind;
      logic [15:0] dur;
   } psw_pt_t;

   typedef struct packed {
      logic [6:0] rsvd;
      logic [2:0] otype;
      logic pre_en;
      logic end_mode;
      logic [1:0] pause_mode;
      logic [1:0] idle_mode;
      logic [7:0] npts;
      logic [7:0] reps;
   } psw_cfg_t;

   typedef struct packed {
      logic hiz;
      logic [11:0] code;
   } psw_os_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PRE = 4'b0010,
      ST_RUN = 4'b0100,
      ST_DONE = 4'b1000
   } psw_st_t;

   localparam psw_cfg_t CFG_RST = 32'h0000_0101;
   localparam psw_pt_t PT_RST = 32'h0000_0001;
   localparam psw_os_t OS_HIZ = 13'h1000;
   localparam psw_os_t OS_ZERO = 13'h0000;
endpackage : psw_pkg

// File: verification/psw_pins.sv
module psw_pins (
   input wire logic clk,
   input wire logic [15:0] o,
   input wire logic [15:0] oe,
   input wire logic [15:0] pu,
   input wire logic [15:0] pd,
   output logic [15:0] lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] flt_q = 16'h0000;
   // Floating pins flip each cycle so a stale level never passes
   always_ff @(posedge clk) flt_q <= ~flt_q;
   // Driver first, then pull-up, then pull-down
   assign lvl = (oe & o) | (~oe & (pu | (~pd & flt_q)));
endmodule : psw_pins

// File: verification/psw_gen_props.sv
module psw_gen_props #(
   parameter logic [15:0] TICK_CYCLES = 16'h2710
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [95:0] ANALOG_OUT_GROUP_A_CODE,
   input wire logic [7:0] ANALOG_OUT_GROUP_A_HIZ,
   input wire logic [15:0] PATTERN_PINS_BANK_ONE_O
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   logic [119:0] last_q;
   logic [15:0] gap_q;
   wire logic [119:0] outs = {ANALOG_OUT_GROUP_A_CODE, ANALOG_OUT_GROUP_A_HIZ,
      PATTERN_PINS_BANK_ONE_O};
   wire logic chg = outs != last_q;
   // Cycles since outputs moved; saturates so reset cannot fake a short gap
   always_ff @(posedge SYS_CLK) begin
      last_q <= outs;
      gap_q <= !RSTN ? 16'hffff : chg ? 16'h0000 : (&gap_q ? gap_q : gap_q + 16'h0001);
   end
   a_out_tick: assert property (chg |-> gap_q >= TICK_CYCLES - 16'h0001)
      else $error("outputs moved between ticks");
   a_rst_state: assert property ($rose(RSTN) |-> &ANALOG_OUT_GROUP_A_HIZ
      && ANALOG_OUT_GROUP_A_CODE == 96'h0) else $error("outputs not idle after reset");
   a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
      && $stable(S_AXI_RDATA)) else $error("read data not held");
   a_r_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   a_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("ar taken");
   a_aw_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY) else $error("aw taken");
   a_aw_once: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY [*3])
      else $error("aw ready too soon");
   c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
   c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
   c_tick: cover property (chg && gap_q == TICK_CYCLES - 16'h0001);
endmodule : psw_gen_props
bind psw_gen psw_gen_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// File: verification/psw_gen_tb.sv
module psw_gen_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] TK = 16'h0040;
   logic SYS_CLK = 1'b0, RSTN = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
   logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
   logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdat, st1;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
   logic [95:0] ANALOG_OUT_GROUP_A_CODE, ANALOG_OUT_GROUP_B_CODE;
   logic [7:0] ANALOG_OUT_GROUP_A_HIZ, ANALOG_OUT_GROUP_B_HIZ;
   logic [15:0] PATTERN_PINS_BANK_ONE_O, PATTERN_PINS_BANK_ONE_OE, PATTERN_PINS_BANK_ONE_PU;
   logic [15:0] PATTERN_PINS_BANK_ONE_PD, PATTERN_PINS_BANK_TWO_O, PATTERN_PINS_BANK_TWO_OE;
   logic [15:0] PATTERN_PINS_BANK_TWO_PU, PATTERN_PINS_BANK_TWO_PD, pin_lvl;
   int n_mismatch = 0, tests_run = 0;
   psw_gen #(.TICK_CYCLES(TK)) dut (.*);
   psw_pins pins (.clk(SYS_CLK), .o(PATTERN_PINS_BANK_ONE_O), .oe(PATTERN_PINS_BANK_ONE_OE),
      .pu(PATTERN_PINS_BANK_ONE_PU), .pd(PATTERN_PINS_BANK_ONE_PD), .lvl(pin_lvl));
   // Free-running system clock
   initial begin
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
   endtask : wr
   // Ready raised late so the held read answer is exercised
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge SYS_CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b1;
      @(posedge SYS_CLK);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask : rd
   // Poll until done, then allow the one-sample output latency
   task automatic wait_st(input logic [31:0] ch);
      int n;
      wr(12'h008, ch);
      rdat = 32'h0;
      for (n = 0; n < 400 && rdat[3:0] !== 4'h8; n++) rd(12'h01c, rdat, resp);
      chk("state", 32'h8, {28'h0, rdat[3:0]});
      repeat (2 * TK) @(posedge SYS_CLK);
   endtask : wait_st
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   // Hang guard, well beyond the expected run
   initial begin
      #500us;
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      rd(12'h00c, rdat, resp);
      chk("cfg reset", 32'h0000_0101, rdat);
      rd(12'h010, rdat, resp);
      chk("pre reset", 32'h0000_0001, rdat);
      rd(12'h040, rdat, resp);
      chk("unmapped", 32'h2, {30'h0, resp});
      $display("test registers done");
      wr(12'h014, 32'h0);
      wr(12'h018, 32'h1002_0002);
      wr(12'h018, 32'hf003_0001);
      wr(12'h010, 32'h2002_0001);
      wr(12'h00c, 32'h0030_0202);
      wr(12'h000, 32'h0000_0100);
      wait_st(32'h0);
      chk("ch0 code", 32'hfff, {20'h0, ANALOG_OUT_GROUP_A_CODE[11:0]});
      chk("ch1 hiz", 32'h1, {31'h0, ANALOG_OUT_GROUP_A_HIZ[1]});
      chk("grp b hiz", 32'hff, {24'h0, ANALOG_OUT_GROUP_B_HIZ});
      rd(12'h01c, rdat, resp);
      chk("passes", 32'h2, {24'h0, rdat[23:16]});
      $display("test analog done");
      wr(12'h008, 32'h10);
      wr(12'h014, 32'h0);
      wr(12'h018, 32'h0012_0001);
      wr(12'h00c, 32'h0010_0101);
      // Park other digital channels
      for (int i = 17; i < 48; i++) begin
         wr(12'h008, i);
         wr(12'h014, 32'h0);
         wr(12'h018, 32'h0);
      end
      wr(12'h004, 32'h1);
      wait_st(32'h10);
      rd(12'h020, rdat, resp);
      chk("pin reg", 32'h1, {31'h0, rdat[0]});
      chk("pin level", 32'h1, {31'h0, pin_lvl[0]});
      $display("test digital done");
      wr(12'h008, 32'h2);
      wr(12'h014, 32'h0);
      wr(12'h018, 32'h3002_0005);
      wr(12'h00c, 32'h0004_0100);
      wr(12'h000, 32'h0000_0102);
      repeat (8 * TK) @(posedge SYS_CLK);
      wr(12'h000, 32'h0000_0202);
      repeat (2 * TK) @(posedge SYS_CLK);
      rd(12'h01c, st1, resp);
      repeat (3 * TK) @(posedge SYS_CLK);
      rd(12'h01c, rdat, resp);
      chk("paused stat", st1, rdat);
      chk("paused flag", 32'h1, {31'h0, rdat[4]});
      chk("pause out", 32'h0, {19'h0, ANALOG_OUT_GROUP_A_HIZ[2], ANALOG_OUT_GROUP_A_CODE[35:24]});
      wr(12'h000, 32'h0000_0302);
      wait_st(32'h2);
      chk("end code", 32'h300, {20'h0, ANALOG_OUT_GROUP_A_CODE[35:24]});
      $display("test pause done");
      complete_run();
   end
endmodule : psw_gen_tb
